/* File: design/lcc_regs.sv */
// Function
// - Channel A code bits 9:8 live in bits 1:0 of register 03h, reset zero.
// - Channel A code bits 7:0 live in register 04h, reset zero.
// - Channel B code bits 9:8 live in bits 1:0 of register 05h, reset zero.
// - Channel B code bits 7:0 live in register 06h, reset zero.
// - Channel C code bits 9:8 live in bits 1:0 of register 07h, reset zero.
// - Every code from zero to all ones is accepted unchanged.
// - Code zero gives zero current; each step adds about 2.47 mA.
// - Channel C code bits 7:0 live in register 08h, reset zero.
//
// Top of the LED channel current register bank.
// Assumes a simple strobe bus synchronous to CLK; read data one cycle later.
`timescale 1ns/1ps
`default_nettype none
module lcc_regs
   import lcc_pkg::*;
(
   input wire logic CLK, // System clock, 125 MHz.
   input wire logic RST_N, // Asynchronous reset, active low.
   input wire logic [LCC_ADDR_W-1:0] ADDR, // Register address.
   input wire logic [LCC_DATA_W-1:0] WDATA, // Write data.
   input wire logic WR, // Write strobe, one cycle.
   input wire logic RD, // Read strobe, one cycle.
   output logic [LCC_DATA_W-1:0] RDATA, // Read data, valid cycle after RD.
   output logic [LCC_CODE_W-1:0] CHAN_A_CURRENT_CODE, // Channel A current code.
   output logic [LCC_CODE_W-1:0] CHAN_B_CURRENT_CODE, // Channel B current code.
   output logic [LCC_CODE_W-1:0] CHAN_C_CURRENT_CODE, // Channel C current code.
   output logic [LCC_NUM_CHAN-1:0] CODE_UPDATED // Pulse per write to a channel's register.
);
   localparam logic [7:0] HIGH_ADDRS [LCC_NUM_CHAN] =
      '{LCC_CHAN_A_CURRENT_HIGH, LCC_CHAN_B_CURRENT_HIGH, LCC_CHAN_C_CURRENT_HIGH};
   localparam logic [7:0] LOW_ADDRS [LCC_NUM_CHAN] =
      '{LCC_CHAN_A_CURRENT_LOW, LCC_CHAN_B_CURRENT_LOW, LCC_CHAN_C_CURRENT_LOW};

   lcc_code_if codes ();

   logic [LCC_DATA_W-1:0] rdata_ff;
   logic [LCC_DATA_W-1:0] nxt_rdata;
   logic [LCC_CODE_W-1:0] code_ff [LCC_NUM_CHAN];
   logic [LCC_NUM_CHAN-1:0] upd_ff;

   // One register pair per channel; each stores any full 10-bit code.
   generate
      for (genvar i = 0; i < LCC_NUM_CHAN; i++) begin : g_chan
         lcc_chan_reg #(
            .HIGH_ADDR(HIGH_ADDRS[i]),
            .LOW_ADDR(LOW_ADDRS[i])
         ) u_chan (
            .clk(CLK),
            .rst_n(RST_N),
            .wr(WR),
            .addr(ADDR),
            .wdata(WDATA),
            .code(codes.code[i]),
            .upd(codes.upd[i])
         );
      end
   endgenerate

   // Returns the read value of one address; high registers pad with zeros.
   function automatic logic [7:0] read_mux(input logic [7:0] a,
                                           input logic [LCC_CODE_W-1:0] c0,
                                           input logic [LCC_CODE_W-1:0] c1,
                                           input logic [LCC_CODE_W-1:0] c2);
      logic [7:0] r;
      r = LCC_UNMAPPED_DATA;
      unique case (a)
         LCC_CHAN_A_CURRENT_HIGH: r = {6'h00, c0[9:8]};
         LCC_CHAN_A_CURRENT_LOW: r = c0[7:0];
         LCC_CHAN_B_CURRENT_HIGH: r = {6'h00, c1[9:8]};
         LCC_CHAN_B_CURRENT_LOW: r = c1[7:0];
         LCC_CHAN_C_CURRENT_HIGH: r = {6'h00, c2[9:8]};
         LCC_CHAN_C_CURRENT_LOW: r = c2[7:0];
         default: r = LCC_UNMAPPED_DATA;
      endcase
      return r;
   endfunction : read_mux

   // Read data is formed from the stored codes and held for one cycle.
   always_comb begin
      nxt_rdata = RD ? read_mux(ADDR, codes.code[0], codes.code[1], codes.code[2])
                     : LCC_UNMAPPED_DATA;
   end

   // Read data register; zero outside the answer cycle.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // Codes leave through flip-flops so the current DAC sees clean values.
   // A code of zero requests zero current; current scales linearly per step.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int i = 0; i < LCC_NUM_CHAN; i++) begin
            code_ff[i] <= '0;
         end
         upd_ff <= '0;
      end else begin
         for (int i = 0; i < LCC_NUM_CHAN; i++) begin
            code_ff[i] <= codes.code[i];
         end
         upd_ff <= codes.upd;
      end
   end

   assign RDATA = rdata_ff;
   assign CHAN_A_CURRENT_CODE = code_ff[0];
   assign CHAN_B_CURRENT_CODE = code_ff[1];
   assign CHAN_C_CURRENT_CODE = code_ff[2];
   assign CODE_UPDATED = upd_ff;
endmodule : lcc_regs
`default_nettype wire

/* File: shared/lcc_pkg.sv */
// Package for the LED channel current register bank.
// Assumes an 8-bit register address space and 8-bit data.
package lcc_pkg;
   localparam int LCC_ADDR_W = 8;
   localparam int LCC_DATA_W = 8;
   localparam int LCC_CODE_W = 10;
   localparam int LCC_NUM_CHAN = 3;
   localparam int LCC_HIGH_W = 2;
   // Register offsets.
   localparam logic [7:0] LCC_CHAN_A_CURRENT_HIGH = 8'h03;
   localparam logic [7:0] LCC_CHAN_A_CURRENT_LOW = 8'h04;
   localparam logic [7:0] LCC_CHAN_B_CURRENT_HIGH = 8'h05;
   localparam logic [7:0] LCC_CHAN_B_CURRENT_LOW = 8'h06;
   localparam logic [7:0] LCC_CHAN_C_CURRENT_HIGH = 8'h07;
   localparam logic [7:0] LCC_CHAN_C_CURRENT_LOW = 8'h08;
   // Reset values.
   localparam logic [7:0] LCC_HIGH_RESET = 8'h00;
   localparam logic [7:0] LCC_LOW_RESET = 8'h00;
   // Field position of the high code bits inside a high register.
   localparam int LCC_HIGH_LSB = 0;
   // Nominal current per code step in microamps.
   localparam int LCC_STEP_UA = 2470;
   // Answer returned for an unmapped address.
   localparam logic [7:0] LCC_UNMAPPED_DATA = 8'h00;
endpackage : lcc_pkg

/* File: shared/lcc_code_if.sv */
// Interface carrying the three channel current codes between modules.
// Assumes the codes are driven by the register bank only.
`timescale 1ns/1ps
`default_nettype none
interface lcc_code_if;
   import lcc_pkg::*;
   logic [LCC_CODE_W-1:0] code [LCC_NUM_CHAN];
   logic [LCC_NUM_CHAN-1:0] upd;
   modport src (output code, output upd);
   modport dst (input code, input upd);
endinterface : lcc_code_if
`default_nettype wire

/* File: design/lcc_chan_reg.sv */
// One channel's split 10-bit current code: high and low register halves.
// Assumes one-cycle write strobes synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module lcc_chan_reg
   import lcc_pkg::*;
#(
   parameter logic [7:0] HIGH_ADDR = 8'h03,
   parameter logic [7:0] LOW_ADDR = 8'h04
) (
   input wire logic clk, // System clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic wr, // Write strobe.
   input wire logic [7:0] addr, // Register address.
   input wire logic [7:0] wdata, // Write data.
   output logic [LCC_CODE_W-1:0] code, // Assembled current code.
   output logic upd // Pulse when either half was written.
);
   logic [LCC_HIGH_W-1:0] high_ff;
   logic [7:0] low_ff;
   logic upd_ff;

   // High half keeps only its two code bits; writes to upper bits are dropped.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         high_ff <= LCC_HIGH_RESET[LCC_HIGH_W-1:0];
      end else if (wr && addr == HIGH_ADDR) begin
         high_ff <= wdata[LCC_HIGH_LSB +: LCC_HIGH_W];
      end
   end

   // Low half holds all eight low code bits.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_ff <= LCC_LOW_RESET;
      end else if (wr && addr == LOW_ADDR) begin
         low_ff <= wdata;
      end
   end

   // Update pulse follows any write to this channel.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         upd_ff <= 1'b0;
      end else begin
         upd_ff <= wr && (addr == HIGH_ADDR || addr == LOW_ADDR);
      end
   end

   assign code = {high_ff, low_ff};
   assign upd = upd_ff;
endmodule : lcc_chan_reg
`default_nettype wire

/* File: sim/lcc_host.sv */
// Host model that drives the register strobe bus of the current register bank.
// Assumes callers enter its task right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module lcc_host (
   input wire logic clk, // Clock.
   output logic [7:0] addr, // Address.
   output logic [7:0] wdata, // Write data.
   output logic wr, // Write strobe.
   output logic rd // Read strobe.
);
   // One transfer a cycle; any code value is sent as given.
   task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= r;
      @(posedge clk);
   endtask : xfer
   // Bus is idle at time zero.
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end
endmodule : lcc_host
`default_nettype wire

/* File: sim/lcc_regs_sva.sv */
// Checker on the ports of the current register bank.
// Assumes one-cycle strobes and codes that follow a write by two edges.
`timescale 1ns/1ps
`default_nettype none
module lcc_regs_sva
   import lcc_pkg::*;
(
   input wire logic CLK, // Clock.
   input wire logic RST_N, // Reset, active low.
   input wire logic [LCC_ADDR_W-1:0] ADDR, // Address.
   input wire logic [LCC_DATA_W-1:0] WDATA, // Write data.
   input wire logic WR, // Write strobe.
   input wire logic RD, // Read strobe.
   input wire logic [LCC_DATA_W-1:0] RDATA, // Read data.
   input wire logic [LCC_CODE_W-1:0] CHAN_A_CURRENT_CODE, // Code A.
   input wire logic [LCC_CODE_W-1:0] CHAN_B_CURRENT_CODE, // Code B.
   input wire logic [LCC_CODE_W-1:0] CHAN_C_CURRENT_CODE, // Code C.
   input wire logic [LCC_NUM_CHAN-1:0] CODE_UPDATED // Update pulses.
);
   // Short views of the three codes.
   wire logic [9:0] ca = CHAN_A_CURRENT_CODE;
   wire logic [9:0] cb = CHAN_B_CURRENT_CODE;
   wire logic [9:0] cc = CHAN_C_CURRENT_CODE;
   default clocking cb_clk @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   AST_RD_AH: assert property (RD && ADDR == 8'h03 |=> RDATA == {6'h00, ca[9:8]})
      else $error("channel A high read wrong");
   AST_RD_AL: assert property (RD && ADDR == 8'h04 |=> RDATA == ca[7:0])
      else $error("channel A low read wrong");
   AST_RD_BH: assert property (RD && ADDR == 8'h05 |=> RDATA == {6'h00, cb[9:8]})
      else $error("channel B high read wrong");
   AST_RD_BL: assert property (RD && ADDR == 8'h06 |=> RDATA == cb[7:0])
      else $error("channel B low read wrong");
   AST_RD_CH: assert property (RD && ADDR == 8'h07 |=> RDATA == {6'h00, cc[9:8]})
      else $error("channel C high read wrong");
   AST_RD_CL: assert property (RD && ADDR == 8'h08 |=> RDATA == cc[7:0])
      else $error("channel C low read wrong");
   AST_WR_AL: assert property (WR && ADDR == 8'h04 |->
      ##2 ca[7:0] == $past(WDATA, 2))
      else $error("channel A low code not taken");
   AST_WR_BL: assert property (WR && ADDR == 8'h06 |->
      ##2 cb[7:0] == $past(WDATA, 2))
      else $error("channel B low code not taken");
   AST_WR_CH: assert property (WR && ADDR == 8'h07 |->
      ##2 {6'h00, cc[9:8]} == ($past(WDATA, 2) & 8'h03))
      else $error("channel C high code not taken");
   AST_UPD_A: assert property (WR && (ADDR == 8'h03 || ADDR == 8'h04) |->
      ##2 CODE_UPDATED[0])
      else $error("channel A update pulse missing");
   AST_UPD_B: assert property (WR && (ADDR == 8'h05 || ADDR == 8'h06) |->
      ##2 CODE_UPDATED[1])
      else $error("channel B update pulse missing");
   AST_UPD_C: assert property (WR && (ADDR == 8'h07 || ADDR == 8'h08) |->
      ##2 CODE_UPDATED[2])
      else $error("channel C update pulse missing");
   AST_UPD_B_QUIET: assert property (!(WR && (ADDR == 8'h05 || ADDR == 8'h06)) |->
      ##2 !CODE_UPDATED[1])
      else $error("channel B update pulse without a write");
endmodule : lcc_regs_sva
bind lcc_regs lcc_regs_sva i_lcc_regs_sva (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
   .WR(WR), .RD(RD), .RDATA(RDATA), .CHAN_A_CURRENT_CODE(CHAN_A_CURRENT_CODE),
   .CHAN_B_CURRENT_CODE(CHAN_B_CURRENT_CODE), .CHAN_C_CURRENT_CODE(CHAN_C_CURRENT_CODE),
   .CODE_UPDATED(CODE_UPDATED));
`default_nettype wire

/* File: sim/led_channel_current_regs_bench.sv */
// Self-checking bench for the current register bank with a host model.
// Assumes reads answer one cycle later and codes settle two edges after a write.
`timescale 1ns/1ps
`default_nettype none
module led_channel_current_regs_bench;
   import lcc_pkg::*;
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   logic [7:0] addr, wdata, rdata, a, d;
   logic wr, rd;
   logic rd_d = 1'b0;
   logic [9:0] ca, cb, cc;
   logic [2:0] upd;
   logic [7:0] shadow [3:8] = '{default: 8'h00};
   logic [7:0] exp_q [$];
   int errors = 0;
   int compares = 0;
   int seed = 2;
   always #4 CLK = ~CLK;
   lcc_host i_lcc_host (.clk(CLK), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
   lcc_regs i_lcc_regs (.CLK(CLK), .RST_N(RST_N), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .CHAN_A_CURRENT_CODE(ca), .CHAN_B_CURRENT_CODE(cb),
      .CHAN_C_CURRENT_CODE(cc), .CODE_UPDATED(upd));
   // Counts a comparison and reports a mismatch.
   task automatic check(input logic ok);
      compares++;
      if (ok !== 1'b1) begin
         errors++;
         $display("mismatch at %0t: value differs from expectation", $time);
      end
   endtask : check
   // Writes a register and mirrors it; high halves keep only two bits.
   task automatic wr_reg(input logic [7:0] ra, input logic [7:0] rv);
      if (ra >= 8'h03 && ra <= 8'h08) shadow[ra] = ra[0] ? (rv & 8'h03) : rv;
      i_lcc_host.xfer(1'b1, 1'b0, ra, rv);
   endtask : wr_reg
   // Reads a register and notes the expected answer.
   task automatic rd_reg(input logic [7:0] ra);
      exp_q.push_back((ra >= 8'h03 && ra <= 8'h08) ? shadow[ra] : LCC_UNMAPPED_DATA);
      i_lcc_host.xfer(1'b0, 1'b1, ra, 8'($random(seed)));
   endtask : rd_reg
   // Prints the verdict and ends the run.
   task automatic final_report;
      if (errors == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   // Compares read data in the cycle after each read strobe.
   always @(posedge CLK) begin
      if (rd_d) check(rdata === exp_q.pop_front());
      rd_d <= rd;
   end
   // Cuts a hang short.
   initial begin
      repeat (3000) @(posedge CLK);
      errors++;
      final_report;
   end
   // Reset values, full-scale codes, then random back-to-back traffic.
   initial begin
      repeat (5) @(posedge CLK);
      RST_N <= 1'b1;
      for (int i = 2; i < 10; i++) rd_reg(8'(i));
      for (int i = 3; i < 9; i++) wr_reg(8'(i), 8'hff);
      for (int i = 2; i < 10; i++) rd_reg(8'(i));
      check(ca === 10'h3ff && cb === 10'h3ff && cc === 10'h3ff);
      for (int i = 0; i < 200; i++) begin
         a = 8'h02 + 8'($random(seed) & 7);
         d = 8'($random(seed));
         if ($random(seed) & 1) wr_reg(a, d);
         else rd_reg(a);
      end
      repeat (3) i_lcc_host.xfer(1'b0, 1'b0, ~a, ~d);
      // A lone channel B write pulses only its own update bit two edges later.
      wr_reg(8'h06, d);
      i_lcc_host.xfer(1'b0, 1'b0, ~a, ~d);
      #1;
      check(upd === 3'b010);
      check(ca === {shadow[3][1:0], shadow[4]} && cb === {shadow[5][1:0], shadow[6]});
      check(cc === {shadow[7][1:0], shadow[8]} && exp_q.size() == 0);
      final_report;
   end
endmodule : led_channel_current_regs_bench
`default_nettype wire
